// >>> dv/dsaf_host.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// host side of the byte port, one request at a time
module dsaf_host
(
   // clock
   input wire logic core_clk,
   // byte port
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata_ff,
   input wire logic reg_rvalid_ff
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // released lines show the inverse, so a stale value never looks right
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   // answer is registered on the taken edge and read 1 ns after it
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      ok = reg_rvalid_ff;
      d = reg_rdata_ff;
   endtask
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) \
      begin \
         err_count++; \
         $display("BAD %0t mismatch got %h exp %h", $time, got, exp); \
      end \
   end
module testbench
   import dsaf_pkg::*;
;
   logic core_clk, resetn, ce, reg_wr, reg_rd, pin, fault, sig_ok, mon_valid;
   logic [7:0] reg_addr, reg_wdata;
   logic [15:0] mon_val [DSAF_NCH];
   logic [15:0] t_ah [DSAF_NCH];
   logic [15:0] t_al [DSAF_NCH];
   logic [15:0] t_wh [DSAF_NCH];
   logic [15:0] t_wl [DSAF_NCH];
   wire [7:0] reg_rdata_ff;
   wire reg_rvalid_ff, tx_off_ff, sig_det_ff, data_not_ready_ff;
   int err_count = 0;
   int num_checks = 0;
   logic [15:0] vals [4] = '{16'h0400, 16'h0050, 16'h0300, 16'hff00};
   logic [3:0] flg;
   logic [15:0] alm, wrn;
   ////////////////////////////////////////////////////////////////////////////
   dsaf_regs #(.READY_CYCLES(50), .RESP_CYCLES(20)) dut
   (
      .core_clk(core_clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
      .tx_disable_pin(pin), .laser_fault(fault), .tx_off_ff(tx_off_ff),
      .rx_signal_ok(sig_ok), .sig_det_ff(sig_det_ff), .mon_valid(mon_valid),
      .mon_val(mon_val), .thr_alm_hi(t_ah), .thr_alm_lo(t_al), .thr_wrn_hi(t_wh),
      .thr_wrn_lo(t_wl), .data_not_ready_ff(data_not_ready_ff)
   );
   dsaf_host h
   (
      .core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
      .reg_rvalid_ff(reg_rvalid_ff)
   );
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      h.rd(a, d, ok);
      `CHK(ok, 1'b1)
      `CHK(d, e)
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // far beyond the few hundred cycles the sequence needs
   initial
   begin
      repeat (5000) @(posedge core_clk);
      err_count++;
      wrap_up;
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      resetn = 1'b0;
      ce = 1'b1;
      pin = 1'b0;
      fault = 1'b0;
      sig_ok = 1'b1;
      mon_valid = 1'b0;
      for (int c = 0; c < DSAF_NCH; c++)
      begin
         mon_val[c] = 16'h0180;
         t_ah[c] = 16'h0300;
         t_wh[c] = 16'h0200;
         t_wl[c] = 16'h0100;
         t_al[c] = 16'h0080;
      end
      repeat (8) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (10) @(posedge core_clk);
      `CHK(data_not_ready_ff, 1'b1)
      chk_rd(8'h6e, 8'h01);
      `CHK(tx_off_ff, 1'b0)
      h.wr(8'h6e, 8'hff);
      #1;
      `CHK(tx_off_ff, 1'b1)
      chk_rd(8'h6e, 8'h41);
      h.wr(8'h6e, 8'h00);
      pin <= 1'b1;
      repeat (8) @(posedge core_clk);
      chk_rd(8'h6e, 8'h81);
      `CHK(tx_off_ff, 1'b1)
      pin <= 1'b0;
      fault <= 1'b1;
      sig_ok <= 1'b0;
      repeat (8) @(posedge core_clk);
      chk_rd(8'h6e, 8'h07);
      `CHK(sig_det_ff, 1'b0)
      fault <= 1'b0;
      sig_ok <= 1'b1;
      for (int i = 0; i < 60 && data_not_ready_ff !== 1'b0; i++) @(posedge core_clk);
      `CHK(data_not_ready_ff, 1'b0)
      chk_rd(8'h6e, 8'h00);
      chk_rd(8'h72, 8'h00);
      // temperature is signed, so the last value is low there and high elsewhere
      for (int c = 0; c < DSAF_NCH; c++)
      begin
         for (int k = 0; k < 4; k++)
         begin
            @(posedge core_clk);
            mon_val[c] <= vals[k];
            mon_valid <= 1'b1;
            @(posedge core_clk);
            mon_valid <= 1'b0;
            mon_val[c] <= 16'h0180;
            repeat (2) @(posedge core_clk);
            flg = (k == 0) ? 4'b1010 : (k == 1) ? 4'b0101 : (k == 2) ? 4'b0010 :
               (c == 0) ? 4'b0101 : 4'b1010;
            alm = {14'h0000, flg[3], flg[2]} << (14 - 2 * c);
            wrn = {14'h0000, flg[1], flg[0]} << (14 - 2 * c);
            chk_rd(8'h70, alm[15:8]);
            chk_rd(8'h71, alm[7:0]);
            chk_rd(8'h74, wrn[15:8]);
            chk_rd(8'h75, wrn[7:0]);
         end
      end
      chk_rd(8'h6f, 8'h00);
      // enable held low: the write must leave no trace
      ce <= 1'b0;
      h.wr(8'h6e, 8'h40);
      ce <= 1'b1;
      chk_rd(8'h6e, 8'h00);
      // mid-run reset clears the soft bit; first sample then makes data ready
      h.wr(8'h6e, 8'h40);
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      `CHK(data_not_ready_ff, 1'b1)
      mon_valid <= 1'b1;
      @(posedge core_clk);
      mon_valid <= 1'b0;
      @(posedge core_clk);
      `CHK(data_not_ready_ff, 1'b0)
      chk_rd(8'h6e, 8'h00);
      `CHK(tx_off_ff, 1'b0)
      wrap_up;
   end
endmodule

// >>> inc/dsaf_map.svh
`ifndef DSAF_MAP_SVH
`define DSAF_MAP_SVH

// byte offsets in the diagnostic page
`define DSAF_OFS_STATUS_CONTROL 8'h6e
`define DSAF_OFS_ALARM_FLAGS_A 8'h70
`define DSAF_OFS_ALARM_FLAGS_B 8'h71
`define DSAF_OFS_WARNING_FLAGS_A 8'h74
`define DSAF_OFS_WARNING_FLAGS_B 8'h75

// status_control fields
`define DSAF_SC_PIN_DIS_BIT 7
`define DSAF_SC_SOFT_DIS_BIT 6
`define DSAF_SC_FAULT_BIT 2
`define DSAF_SC_SIGDET_BIT 1
`define DSAF_SC_NOT_READY_BIT 0
`define DSAF_SC_RESET 8'h01
`define DSAF_FLAGS_RESET 8'h00

// timing
`define DSAF_CLK_HZ 40000000
`define DSAF_RESP_MS 100
`define DSAF_READY_MS 1000

`endif

// >>> inc/dsaf_pkg.sv
package dsaf_pkg;
   // monitored quantities, in flag-bit order from the top
   typedef enum logic [2:0]
   {
      DSAF_CH_TEMP = 3'h0,
      DSAF_CH_VCC = 3'h1,
      DSAF_CH_BIAS = 3'h2,
      DSAF_CH_TXPWR = 3'h3,
      DSAF_CH_RXPWR = 3'h4
   } dsaf_ch_t;

   localparam int DSAF_NCH = 5;

   typedef enum logic [1:0]
   {
      DSAF_ST_WAIT = 2'b01,
      DSAF_ST_READY = 2'b10
   } dsaf_state_t;
endpackage

// >>> logic/dsaf_regs.sv
`timescale 1ns/1ps
`include "dsaf_map.svh"

module dsaf_regs
   import dsaf_pkg::*;
#(
   parameter int unsigned READY_CYCLES = `DSAF_READY_MS * (`DSAF_CLK_HZ / 1000),
   parameter int unsigned RESP_CYCLES = `DSAF_RESP_MS * (`DSAF_CLK_HZ / 1000)
)
(
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   // host byte access
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_ff,
   output logic reg_rvalid_ff,
   // transmitter
   input wire logic tx_disable_pin,
   input wire logic laser_fault,
   output logic tx_off_ff,
   // receiver
   input wire logic rx_signal_ok,
   output logic sig_det_ff,
   // monitor samples and thresholds
   input wire logic mon_valid,
   input wire logic [15:0] mon_val [DSAF_NCH],
   input wire logic [15:0] thr_alm_hi [DSAF_NCH],
   input wire logic [15:0] thr_alm_lo [DSAF_NCH],
   input wire logic [15:0] thr_wrn_hi [DSAF_NCH],
   input wire logic [15:0] thr_wrn_lo [DSAF_NCH],
   // readiness
   output logic data_not_ready_ff
);

   localparam int CW = $clog2(READY_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser: three flops, change taken when last two agree

   logic pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_dis_ff;
   logic nxt_pin_s1, nxt_pin_s2, nxt_pin_s3, nxt_pin_dis;

   always_comb
   begin
      nxt_pin_s1 = pin_s1_ff;
      nxt_pin_s2 = pin_s2_ff;
      nxt_pin_s3 = pin_s3_ff;
      nxt_pin_dis = pin_dis_ff;
      if (ce)
      begin
         nxt_pin_s1 = tx_disable_pin;
         nxt_pin_s2 = pin_s1_ff;
         nxt_pin_s3 = pin_s2_ff;
         if (pin_s2_ff == pin_s3_ff)
         begin
            nxt_pin_dis = pin_s3_ff;
         end
      end
   end

   // pin asserted at reset: transmitter held off until the pin is seen
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         pin_s1_ff <= 1'b1;
         pin_s2_ff <= 1'b1;
         pin_s3_ff <= 1'b1;
         pin_dis_ff <= 1'b1;
      end
      else
      begin
         pin_s1_ff <= nxt_pin_s1;
         pin_s2_ff <= nxt_pin_s2;
         pin_s3_ff <= nxt_pin_s3;
         pin_dis_ff <= nxt_pin_dis;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status and control

   logic soft_dis_ff, fault_ff;
   logic nxt_soft_dis, nxt_fault, nxt_tx_off, nxt_sig_det;
   logic sc_wr;

   assign sc_wr = ce && reg_wr && (reg_addr == `DSAF_OFS_STATUS_CONTROL);

   always_comb
   begin
      nxt_soft_dis = soft_dis_ff;
      nxt_fault = fault_ff;
      nxt_tx_off = tx_off_ff;
      nxt_sig_det = sig_det_ff;
      if (ce)
      begin
         // only bit 6 is writable; the rest of the byte is status
         if (sc_wr)
         begin
            nxt_soft_dis = reg_wdata[`DSAF_SC_SOFT_DIS_BIT];
         end
         nxt_fault = laser_fault;
         nxt_tx_off = nxt_soft_dis | pin_dis_ff;
         nxt_sig_det = rx_signal_ok;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         soft_dis_ff <= 1'b0;
         fault_ff <= 1'b0;
         tx_off_ff <= 1'b1;
         sig_det_ff <= 1'b0;
      end
      else
      begin
         soft_dis_ff <= nxt_soft_dis;
         fault_ff <= nxt_fault;
         tx_off_ff <= nxt_tx_off;
         sig_det_ff <= nxt_sig_det;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // readiness: first sample or deadline, whichever comes first

   dsaf_state_t state_ff, nxt_state;
   logic [CW-1:0] rdy_cnt_ff, nxt_rdy_cnt;
   logic nxt_not_ready;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_rdy_cnt = rdy_cnt_ff;
      nxt_not_ready = data_not_ready_ff;
      if (ce)
      begin
         case (state_ff)
            DSAF_ST_WAIT:
            begin
               nxt_rdy_cnt = rdy_cnt_ff + CW'(1);
               // deadline guards against a monitor that never reports
               if (mon_valid || rdy_cnt_ff >= CW'(READY_CYCLES - 1))
               begin
                  nxt_state = DSAF_ST_READY;
                  nxt_not_ready = 1'b0;
               end
            end
            DSAF_ST_READY:
            begin
               nxt_not_ready = 1'b0;
            end
            default:
            begin
               nxt_state = DSAF_ST_WAIT;
               nxt_rdy_cnt = '0;
               nxt_not_ready = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         state_ff <= DSAF_ST_WAIT;
         rdy_cnt_ff <= '0;
         data_not_ready_ff <= 1'b1;
      end
      else
      begin
         state_ff <= nxt_state;
         rdy_cnt_ff <= nxt_rdy_cnt;
         data_not_ready_ff <= nxt_not_ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // threshold compares; flags follow each new sample

   logic [9:0] alm_cmp, wrn_cmp;
   logic [9:0] alm_ff, wrn_ff, nxt_alm, nxt_wrn;

   for (genvar c = 0; c < DSAF_NCH; c++)
   begin : g_cmp
      logic [15:0] v, ah, al, wh, wl;
      // temperature is signed: flipping the sign bit makes unsigned compares follow signed order
      localparam logic [15:0] FLIP = (c == int'(DSAF_CH_TEMP)) ? 16'h8000 : 16'h0000;
      assign v = mon_val[c] ^ FLIP;
      assign ah = thr_alm_hi[c] ^ FLIP;
      assign al = thr_alm_lo[c] ^ FLIP;
      assign wh = thr_wrn_hi[c] ^ FLIP;
      assign wl = thr_wrn_lo[c] ^ FLIP;
      assign alm_cmp[9 - 2 * c] = v > ah;
      assign alm_cmp[8 - 2 * c] = v < al;
      assign wrn_cmp[9 - 2 * c] = v > wh;
      assign wrn_cmp[8 - 2 * c] = v < wl;
   end

   always_comb
   begin
      nxt_alm = alm_ff;
      nxt_wrn = wrn_ff;
      if (ce && mon_valid)
      begin
         nxt_alm = alm_cmp;
         nxt_wrn = wrn_cmp;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         alm_ff <= 10'h000;
         wrn_ff <= 10'h000;
      end
      else
      begin
         alm_ff <= nxt_alm;
         wrn_ff <= nxt_wrn;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped bytes answer zero

   logic [7:0] sc_byte, rd_mux;
   logic [7:0] nxt_rdata;
   logic nxt_rvalid;

   always_comb
   begin
      sc_byte = 8'h00;
      sc_byte[`DSAF_SC_PIN_DIS_BIT] = pin_dis_ff;
      sc_byte[`DSAF_SC_SOFT_DIS_BIT] = soft_dis_ff;
      sc_byte[`DSAF_SC_FAULT_BIT] = fault_ff;
      sc_byte[`DSAF_SC_SIGDET_BIT] = ~sig_det_ff;
      sc_byte[`DSAF_SC_NOT_READY_BIT] = data_not_ready_ff;
   end

   always_comb
   begin
      case (reg_addr)
         `DSAF_OFS_STATUS_CONTROL: rd_mux = sc_byte;
         `DSAF_OFS_ALARM_FLAGS_A: rd_mux = alm_ff[9:2];
         `DSAF_OFS_ALARM_FLAGS_B: rd_mux = {alm_ff[1:0], 6'h00};
         `DSAF_OFS_WARNING_FLAGS_A: rd_mux = wrn_ff[9:2];
         `DSAF_OFS_WARNING_FLAGS_B: rd_mux = {wrn_ff[1:0], 6'h00};
         default: rd_mux = `DSAF_FLAGS_RESET;
      endcase
   end

   always_comb
   begin
      nxt_rdata = reg_rdata_ff;
      nxt_rvalid = reg_rvalid_ff;
      if (ce)
      begin
         nxt_rvalid = reg_rd;
         if (reg_rd)
         begin
            nxt_rdata = rd_mux;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         reg_rdata_ff <= 8'h00;
         reg_rvalid_ff <= 1'b0;
      end
      else
      begin
         reg_rdata_ff <= nxt_rdata;
         reg_rvalid_ff <= nxt_rvalid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   // cycles the transmitter control lags its causes
   logic [31:0] lag_cnt_ff;
   always_ff @(posedge core_clk)
   begin
      if (!resetn || tx_off_ff == (soft_dis_ff | pin_dis_ff))
      begin
         lag_cnt_ff <= 32'h0;
      end
      else
      begin
         lag_cnt_ff <= lag_cnt_ff + 32'h1;
      end
   end

   property p_pin_follow;
      (ce && pin_s2_ff == pin_s3_ff) ##1 ce |=> pin_dis_ff == $past(pin_s3_ff, 2);
   endproperty
   a_pin_follow: assert property (p_pin_follow) else $error("pin state lost");

   property p_soft_write;
      sc_wr |=> soft_dis_ff == $past(reg_wdata[`DSAF_SC_SOFT_DIS_BIT]);
   endproperty
   a_soft_write: assert property (p_soft_write) else $error("soft bit not written");

   property p_or;
      ce && $past(ce) |-> tx_off_ff == ($past(pin_dis_ff) | ($past(sc_wr)
         ? $past(reg_wdata[`DSAF_SC_SOFT_DIS_BIT]) : $past(soft_dis_ff)));
   endproperty
   a_or: assert property (p_or) else $error("disable not ORed");

   property p_resp;
      lag_cnt_ff < RESP_CYCLES;
   endproperty
   a_resp: assert property (p_resp) else $error("soft command too slow");

   property p_sigdet_read;
      ce && reg_rd && reg_addr == `DSAF_OFS_STATUS_CONTROL
         |=> reg_rvalid_ff && reg_rdata_ff[`DSAF_SC_SIGDET_BIT] == ~$past(sig_det_ff)
         && reg_rdata_ff[5:3] == 3'h0 && reg_rdata_ff[2] == $past(fault_ff);
   endproperty
   a_sigdet_read: assert property (p_sigdet_read) else $error("status byte wrong");

   property p_ready;
      ce && state_ff == DSAF_ST_WAIT && mon_valid |=> !data_not_ready_ff;
   endproperty
   a_ready: assert property (p_ready) else $error("not ready after sample");

   property p_deadline;
      (state_ff == DSAF_ST_WAIT) ? rdy_cnt_ff < CW'(READY_CYCLES) : !data_not_ready_ff;
   endproperty
   a_deadline: assert property (p_deadline) else $error("ready deadline missed");

   property p_temp_alarm;
      ce && mon_valid && $signed(mon_val[0]) > $signed(thr_alm_hi[0]) |=> alm_ff[9];
   endproperty
   a_temp_alarm: assert property (p_temp_alarm) else $error("temp alarm missed");

   property p_rx_warn;
      ce && reg_rd && reg_addr == `DSAF_OFS_WARNING_FLAGS_B
         |=> reg_rdata_ff == {$past(wrn_ff[1:0]), 6'h00};
   endproperty
   a_rx_warn: assert property (p_rx_warn) else $error("rx warning byte wrong");

   property p_unmapped;
      ce && reg_rd && reg_addr == 8'h6f |=> reg_rdata_ff == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped byte not zero");

   c_soft_on: cover property (sc_wr && reg_wdata[`DSAF_SC_SOFT_DIS_BIT] ##1 tx_off_ff);
   c_ready: cover property (data_not_ready_ff ##1 !data_not_ready_ff);
   c_alarm: cover property (ce && mon_valid ##1 alm_ff[1]);
   c_pin: cover property (!pin_dis_ff ##1 pin_dis_ff);

endmodule
